/* logic/lcd_drive_timing.sv */
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
// Notes on behaviour
// - Seven duty ratios, 1/32 through 1/66
// - 1/66 duty drives at most 65 lines
// - Half-line wave: polarity equals line clock
// - Frame wave: polarity inverts each frame
// - N-line wave: polarity inverts every n lines
// - Combine option XORs n-line and frame polarity
// - Ratio one: 500 kHz gives about 80 Hz
// - Frame period scales with duty correction
// - Divider offers 2,1,1/2,1/3,1/4,1/6,1/8
// - Screen off blanks but keeps registers
// - Writing one to bit 6 enters standby
// - Standby halts oscillator and ignores clock
// - Standby clears all registers except sleep
// - Standby pin levels depend on master/slave
// - Wake write ignores screen and pointer bits
// - Select pin low means master, high slave
// - Master drives sync, slave follows them
// - Slave ignores duty, waveform, n-line settings
// - Busy and unused pointer, mode, n-line bits ignore writes, read zero
module lcd_drive_timing
    import lcd_timing_pkg::*;
#(
    parameter int LINE_TICKS = LINE_TICKS_BASE  // input clocks per line at ratio 1
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Drive clock input (pin, sampled)
    input  wire logic        drive_clk_in,
    input  wire logic        slave_select,       // low = master
    // Sync pins, three signals each
    input  wire logic        line_latch_clock_i,
    output logic             line_latch_clock_o,
    output logic             line_latch_clock_oe,
    input  wire logic        frame_marker_i,
    output logic             frame_marker_o,
    output logic             frame_marker_oe,
    input  wire logic        polarity_i,
    output logic             polarity_o,
    output logic             polarity_oe,
    // Other pins
    output logic             oscillator_output,
    output logic             clock_output,
    output logic             display_enable,
    output logic [6:0]       active_line,
    output logic             line_valid
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]       pointer;     // screen, sleep, reg number
        logic [7:0]       control;     // duty in [2:0]
        logic [7:0]       mode;        // divider, waveform
        logic [7:0]       n_line;      // xor bit, line count
        logic [2:0]       clk_s;       // sync + edge history of drive clock
        logic [2:0]       llc_s;       // sync + history of slave line clock
        logic [2:0]       fm_s;        // sync + history of slave frame marker
        logic [1:0]       pol_s;       // sync of slave polarity
        logic [1:0]       ms_s;        // sync of master/slave pin
        logic [DIV_W-1:0] tick_cnt;    // drive clock edges inside a line
        logic [6:0]       line;        // current line
        logic [4:0]       n_cnt;       // lines since last n-line flip
        logic             frame_pol;   // per-frame polarity
        logic             n_pol;       // per-n-line polarity
        logic             llc;         // line clock out
        logic             fm;          // frame marker out
        logic             pol;         // polarity out
        logic             osc_div;     // clock echo
        logic [31:0]      rdata;
    } state_t;

    state_t s_q, s_d;

    // ----------------------------------------------------------------
    // Combinational helpers
    // ----------------------------------------------------------------
    logic             is_master;
    logic             sleeping;
    logic             clk_edge;
    logic [6:0]       lines_per_frame;
    logic [DIV_W-1:0] ticks_per_line;
    logic [1:0]       wave;
    logic [4:0]       n_lines;
    logic             wr;
    logic             rd;

    assign is_master = ~s_q.ms_s[1];
    assign sleeping  = s_q.pointer[SLEEP_POS];
    // Rising edge of the sampled drive clock; gated off in standby
    assign clk_edge  = s_q.clk_s[1] & ~s_q.clk_s[2] & ~sleeping;
    assign wave      = s_q.mode[WAVE_LSB +: 2];
    assign n_lines   = s_q.n_line[4:0];
    assign wr        = psel & penable & pwrite;
    assign rd        = psel & ~penable & ~pwrite;

    // Lines per frame from the duty field; code 7 (test) falls back to 32
    always_comb begin
        case (s_q.control[2:0])
            3'h0:    lines_per_frame = LINES_32;
            3'h1:    lines_per_frame = LINES_34;
            3'h2:    lines_per_frame = LINES_36;
            3'h3:    lines_per_frame = LINES_48;
            3'h4:    lines_per_frame = LINES_50;
            3'h5:    lines_per_frame = LINES_64;
            DUTY_66: lines_per_frame = LINES_66;
            default: lines_per_frame = LINES_32;
        endcase
    end

    // Line length: base scaled by the divider. Frame period grows with the
    // line count, so longer duties get the duty correction for free.
    always_comb begin
        case (s_q.mode[DIV_LSB +: 3])
            3'h0:    ticks_per_line = DIV_W'(LINE_TICKS / 2);
            3'h1:    ticks_per_line = DIV_W'(LINE_TICKS);
            3'h2:    ticks_per_line = DIV_W'(LINE_TICKS * 2);
            3'h3:    ticks_per_line = DIV_W'(LINE_TICKS * 3);
            3'h4:    ticks_per_line = DIV_W'(LINE_TICKS * 4);
            3'h5:    ticks_per_line = DIV_W'(LINE_TICKS * 6);
            3'h6:    ticks_per_line = DIV_W'(LINE_TICKS * 8);
            default: ticks_per_line = DIV_W'(LINE_TICKS);
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic line_end;
        logic frame_end;
        logic [7:0] wdat;
        line_end  = 1'b0;
        frame_end = 1'b0;
        wdat      = pwdata[7:0];
        s_d = s_q;

        // Pin synchronisers; first stage read only by the second
        s_d.clk_s = {s_q.clk_s[1:0], drive_clk_in};
        s_d.llc_s = {s_q.llc_s[1:0], line_latch_clock_i};
        s_d.fm_s  = {s_q.fm_s[1:0], frame_marker_i};
        s_d.pol_s = {s_q.pol_s[0], polarity_i};
        s_d.ms_s  = {s_q.ms_s[0], slave_select};

        // Master timing generator
        if (is_master && clk_edge) begin
            if (s_q.tick_cnt >= ticks_per_line - DIV_W'(1)) begin
                s_d.tick_cnt = '0;
                line_end     = 1'b1;
            end else begin
                s_d.tick_cnt = s_q.tick_cnt + DIV_W'(1);
            end
            // Line clock high for the first half of each line
            s_d.llc = (s_d.tick_cnt < (ticks_per_line >> 1));
        end
        if (line_end) begin
            if (s_q.line >= lines_per_frame - 7'h01) begin
                s_d.line  = '0;
                frame_end = 1'b1;
            end else begin
                s_d.line = s_q.line + 7'h01;
            end
            s_d.fm = (s_d.line == 7'h00);
            if (frame_end) begin
                s_d.frame_pol = ~s_q.frame_pol;
            end
            // N-line counter; zero count never flips (host keeps 1..31)
            if (s_q.n_cnt + 5'h01 >= n_lines && n_lines != 5'h00) begin
                s_d.n_cnt = '0;
                s_d.n_pol = ~s_q.n_pol;
            end else begin
                s_d.n_cnt = s_q.n_cnt + 5'h01;
            end
        end
        case (wave)
            WAVE_HALF_LINE: s_d.pol = s_d.llc;
            WAVE_FRAME:     s_d.pol = s_d.frame_pol;
            WAVE_N_LINE:    s_d.pol = s_q.n_line[XOR_POS] ? (s_d.n_pol ^ s_d.frame_pol)
                                                          : s_d.n_pol;
            default:        s_d.pol = s_d.frame_pol;
        endcase

        // Slave: follow the master's pins, own settings unused
        if (!is_master) begin
            s_d.tick_cnt = '0;
            s_d.llc      = s_q.llc_s[1];
            s_d.fm       = s_q.fm_s[1];
            s_d.pol      = s_q.pol_s[1];
            if (s_q.llc_s[1] & ~s_q.llc_s[2]) begin
                s_d.line = (s_q.fm_s[1]) ? 7'h00 : s_q.line + 7'h01;
            end
        end

        // Clock echo toggles on each accepted drive clock edge
        if (clk_edge) begin
            s_d.osc_div = ~s_q.osc_div;
        end

        // Register reads, registered for the access phase
        if (rd) begin
            case (paddr)
                REG_POINTER_ADDR: s_d.rdata = {24'h0, s_q.pointer};
                CONTROL_ADDR:     s_d.rdata = {24'h0, s_q.control};
                MODE_ADDR:        s_d.rdata = {24'h0, s_q.mode};
                N_LINE_ADDR:      s_d.rdata = {24'h0, s_q.n_line};
                STATUS_ADDR:      s_d.rdata = {16'h0, s_q.frame_pol, s_q.line, 7'h0,
                                               is_master};
                default:          s_d.rdata = '0;
            endcase
        end

        // Register writes; busy and unused bits masked off, except control bits 7:3, which stay writable
        if (wr) begin
            case (paddr)
                REG_POINTER_ADDR: begin
                    if (sleeping) begin
                        // Waking write keeps only the sleep bit
                        s_d.pointer[SLEEP_POS] = wdat[SLEEP_POS];
                    end else if (wdat[SLEEP_POS]) begin
                        s_d.pointer = 8'h00;
                        s_d.pointer[SLEEP_POS] = 1'b1;
                        s_d.control = 8'h00;
                        s_d.mode    = 8'h00;
                        s_d.n_line  = 8'h00;
                    end else begin
                        s_d.pointer = wdat & POINTER_MASK;
                    end
                end
                CONTROL_ADDR: if (!sleeping) s_d.control = wdat & CONTROL_MASK;
                MODE_ADDR:    if (!sleeping) s_d.mode    = wdat & MODE_MASK;
                N_LINE_ADDR:  if (!sleeping) s_d.n_line  = wdat & N_LINE_MASK;
                default: ;
            endcase
        end

        // Standby stops sequencing; timing restarts from zero on wake
        if (sleeping) begin
            s_d.tick_cnt  = '0;
            s_d.line      = '0;
            s_d.n_cnt     = '0;
            s_d.frame_pol = 1'b0;
            s_d.n_pol     = 1'b0;
            s_d.llc       = 1'b0;
            s_d.fm        = 1'b0;
            s_d.pol       = 1'b0;
            s_d.osc_div   = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign pready  = 1'b1;       // Zero wait states
    assign pslverr = 1'b0;
    assign prdata  = s_q.rdata;

    // Sync pins: master drives them (low in standby), slave floats
    assign line_latch_clock_o  = s_q.llc & is_master;
    assign frame_marker_o      = s_q.fm & is_master;
    assign polarity_o          = s_q.pol & is_master;
    assign line_latch_clock_oe = is_master;
    assign frame_marker_oe     = is_master;
    assign polarity_oe         = is_master;

    // Standby: oscillator output high, clock output low
    assign oscillator_output = sleeping | s_q.osc_div;
    assign clock_output      = ~sleeping & s_q.osc_div;

    // Screen off blanks the drive only; registers stay
    assign display_enable = s_q.pointer[SCREEN_ON_POS] & ~sleeping;
    assign active_line    = s_q.line;
    // Line 66 of a 1/66 frame has no row pin behind it
    assign line_valid     = display_enable && (s_q.line < ROW_PINS);

endmodule

/* logic/lcd_timing_pkg.sv */
package lcd_timing_pkg;

    // ----------------------------------------------------------------
    // Register map (APB byte addresses, one aligned word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_POINTER_ADDR = 8'h00;  // register_pointer_reg
    localparam logic [7:0] CONTROL_ADDR     = 8'h0c;  // control_config_reg
    localparam logic [7:0] MODE_ADDR        = 8'h10;  // mode_config_reg
    localparam logic [7:0] N_LINE_ADDR      = 8'h14;  // n_line_select_reg
    localparam logic [7:0] STATUS_ADDR      = 8'h18;  // line/frame state readback

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int SCREEN_ON_POS  = 7;   // screen_on_bit in register_pointer_reg
    localparam int SLEEP_POS      = 6;   // sleep_bit in register_pointer_reg
    localparam int BUSY_POS       = 5;   // read-only busy flag
    localparam int REG_NUM_LSB    = 0;   // register number, 3 bits
    localparam int XOR_POS        = 5;   // xor_combine_bit in n_line_select_reg
    localparam int WAVE_LSB       = 3;   // waveform_select_field in mode_config_reg
    localparam int DIV_LSB        = 0;   // clock_divider_select in mode_config_reg

    // Writable masks per register
    localparam logic [7:0] POINTER_MASK = 8'hc7;
    localparam logic [7:0] CONTROL_MASK = 8'hff;
    localparam logic [7:0] MODE_MASK    = 8'h1f;
    localparam logic [7:0] N_LINE_MASK  = 8'h3f;

    // ----------------------------------------------------------------
    // Duty ratio codes and line counts
    // ----------------------------------------------------------------
    localparam logic [2:0] DUTY_66 = 3'h6;
    localparam logic [6:0] ROW_PINS = 7'h41;      // 65 row outputs exist
    localparam logic [6:0] LINES_32 = 7'h20;
    localparam logic [6:0] LINES_34 = 7'h22;
    localparam logic [6:0] LINES_36 = 7'h24;
    localparam logic [6:0] LINES_48 = 7'h30;
    localparam logic [6:0] LINES_50 = 7'h32;
    localparam logic [6:0] LINES_64 = 7'h40;
    localparam logic [6:0] LINES_66 = 7'h42;

    // Waveform codes
    localparam logic [1:0] WAVE_HALF_LINE = 2'h0;
    localparam logic [1:0] WAVE_FRAME     = 2'h1;
    localparam logic [1:0] WAVE_N_LINE    = 2'h2;

    // ----------------------------------------------------------------
    // Frame rate: 500 kHz input gives ~80 Hz at ratio 1 with 32 lines.
    // Ticks per line at ratio 1 = 500000 / (80 * 32) ~ 195 input clocks.
    // Ratios 2,1,1/2,1/3,1/4,1/6,1/8 scale that by 1/2..8.
    // ----------------------------------------------------------------
    localparam int REF_CLK_KHZ     = 500;
    localparam int REF_FRAME_HZ    = 80;
    localparam int REF_LINES       = 32;
    localparam int LINE_TICKS_BASE = (REF_CLK_KHZ * 1000) / (REF_FRAME_HZ * REF_LINES);
    localparam int DIV_W           = 12;

endpackage

/* tb/lcd_drive_timing_checker.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Port-level checker with host-write shadows
// ----------------------------------------------------------------
module lcd_drive_timing_checker
    import lcd_timing_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        slave_select,
    input wire logic        line_latch_clock_o,
    input wire logic        line_latch_clock_oe,
    input wire logic        frame_marker_o,
    input wire logic        frame_marker_oe,
    input wire logic        polarity_o,
    input wire logic        polarity_oe,
    input wire logic        oscillator_output,
    input wire logic        clock_output,
    input wire logic        display_enable,
    input wire logic [6:0]  active_line,
    input wire logic        line_valid
);
    logic       wr;        // Completed write
    logic       sleep_q;   // Shadow of the sleep bit
    logic       sleep_d;
    logic [1:0] wave_q;    // Shadow of the waveform field
    logic [1:0] wave_d;
    assign wr = psel && penable && pwrite;
    // Shadow update; mode writes are dropped while asleep, like the device
    always_comb begin
        sleep_d = sleep_q;
        wave_d = wave_q;
        if (wr && paddr == REG_POINTER_ADDR) begin
            sleep_d = pwdata[SLEEP_POS];
            if (pwdata[SLEEP_POS]) begin
                wave_d = 2'h0;
            end
        end else if (wr && paddr == MODE_ADDR && !sleep_q) begin
            wave_d = pwdata[WAVE_LSB +: 2];
        end
    end
    always_ff @(posedge ref_clk) begin
        sleep_q <= rst ? 1'b0 : sleep_d;
        wave_q <= rst ? 2'h0 : wave_d;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Slack of three cycles covers the write-to-state latency
    property p_standby_osc;
        sleep_q [*3] |-> oscillator_output && !clock_output;
    endproperty
    a_standby_osc: assert property (p_standby_osc)
        else $error("standby clock pins wrong");
    property p_standby_sync;
        (sleep_q && !slave_select) [*3] |->
            !line_latch_clock_o && !frame_marker_o && !polarity_o;
    endproperty
    a_standby_sync: assert property (p_standby_sync)
        else $error("standby sync pins not low");
    property p_standby_dark;
        sleep_q [*3] |-> !display_enable && !line_valid;
    endproperty
    a_standby_dark: assert property (p_standby_dark)
        else $error("display on in standby");
    property p_row_limit;
        line_valid |-> active_line < ROW_PINS;
    endproperty
    a_row_limit: assert property (p_row_limit)
        else $error("line beyond row outputs");
    property p_half_line;
        (wave_q == WAVE_HALF_LINE && !sleep_q && !slave_select) [*4] |->
            polarity_o == line_latch_clock_o;
    endproperty
    a_half_line: assert property (p_half_line)
        else $error("polarity differs from line clock");
    property p_frame_flip;
        (wave_q == WAVE_FRAME && !sleep_q) [*4] ##0 $changed(polarity_o) |->
            frame_marker_o || $past(frame_marker_o);
    endproperty
    a_frame_flip: assert property (p_frame_flip)
        else $error("polarity flipped away from frame start");
    property p_master_oe;
        (!slave_select) [*4] |-> line_latch_clock_oe && frame_marker_oe && polarity_oe;
    endproperty
    a_master_oe: assert property (p_master_oe)
        else $error("master not driving sync pins");
    property p_slave_float;
        slave_select [*4] |-> !line_latch_clock_oe && !frame_marker_oe && !polarity_oe;
    endproperty
    a_slave_float: assert property (p_slave_float)
        else $error("slave driving sync pins");
    property p_unmapped;
        psel && !penable && !pwrite && paddr == 8'h04 |=> prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
endmodule
bind lcd_drive_timing lcd_drive_timing_checker u_chk (.*);

/* tb/lcd_far_side.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Far side: free-running panel clock and a master's sync outputs
// ----------------------------------------------------------------
module lcd_far_side (
    output logic drive_clk,
    output logic line_clk,
    output logic frame_mark,
    output logic pol
);
    logic [6:0] tick_q = 7'h00;  // Drive edges over two 16-line frames
    // Input clock runs free; 3 ns offset keeps it off ref_clk edges
    initial begin
        drive_clk = 1'b0;
        #3;
        forever #40 drive_clk = ~drive_clk;
    end
    // Sync waveform as a master chip would send it to slaves
    always @(posedge drive_clk) begin
        tick_q <= tick_q + 7'h01;
    end
    assign line_clk = ~tick_q[1];
    assign frame_mark = (tick_q[5:2] == 4'h0);
    assign pol = tick_q[6];
endmodule

/* tb/lcd_drive_timing_tb.sv */
`timescale 1ns/1ns
module lcd_drive_timing_tb
    import lcd_timing_pkg::*;
;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    localparam int TICKS = 4;    // Shortened line length
    localparam int DRV = 10;     // Drive clock period in ref_clk cycles
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic slave_select = 1'b0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, drv, p_lc, p_fm, p_pol, lc_o, lc_oe, fm_o, fm_oe;
    wire logic pol_o, pol_oe, osc, clk_o, screen_on_bit_en, lvalid;
    wire logic [6:0] act_line;
    int num_errors = 0;
    int comparisons = 0;
    logic [31:0] exp_q[$];   // Expected read data, oldest first
    string name_q[$];
    int n;
    int i;
    logic a;
    logic b;
    logic [31:0] d;
    int lines_tab[8] = '{32, 34, 36, 48, 50, 64, 66, 32};
    int half_tab[7] = '{1, 2, 4, 6, 8, 12, 16};  // Line length in half lines
    logic [7:0] addr_tab[4] = '{REG_POINTER_ADDR, CONTROL_ADDR, MODE_ADDR, N_LINE_ADDR};
    logic [7:0] mask_tab[4] = '{POINTER_MASK & 8'hbf, CONTROL_MASK, MODE_MASK, N_LINE_MASK};
    always #4 ref_clk = ~ref_clk;
    lcd_far_side u_far (.drive_clk(drv), .line_clk(p_lc), .frame_mark(p_fm), .pol(p_pol));
    lcd_drive_timing #(.LINE_TICKS(TICKS)) u_dut (.ref_clk(ref_clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .drive_clk_in(drv),
        .slave_select(slave_select), .line_latch_clock_i(lc_oe ? lc_o : p_lc),
        .line_latch_clock_o(lc_o), .line_latch_clock_oe(lc_oe),
        .frame_marker_i(fm_oe ? fm_o : p_fm), .frame_marker_o(fm_o),
        .frame_marker_oe(fm_oe), .polarity_i(pol_oe ? pol_o : p_pol),
        .polarity_o(pol_o), .polarity_oe(pol_oe), .oscillator_output(osc),
        .clock_output(clk_o), .display_enable(screen_on_bit_en), .active_line(act_line),
        .line_valid(lvalid));
    // ----------------------------------------------------------------
    // Checking and bus tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic [7:0] ad, input logic w, input logic [31:0] wd);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] exp, input string nm);
        exp_q.push_back(exp);
        name_q.push_back(nm);
        apb(ad, 1'b0, 32'h0);
    endtask
    // Monitor: completed read takes the oldest note
    always @(posedge ref_clk) begin
        if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) begin
            check(name_q.pop_front(), prdata, exp_q.pop_front());
        end
    end
    // Line clock rises between two markers (frame rise or polarity change)
    task automatic span(input logic use_pol, output int cnt);
        int t;
        int seen;
        logic pf;
        logic pl;
        logic pp;
        cnt = 0;
        seen = 0;
        pf = fm_o;
        pl = lc_o;
        pp = pol_o;
        for (t = 0; t < 8000 && seen < 2; t++) begin
            @(posedge ref_clk);
            #1;
            if (seen == 1 && lc_o && !pl) cnt++;
            if (use_pol ? (pol_o != pp) : (fm_o && !pf)) seen++;
            pf = fm_o;
            pl = lc_o;
            pp = pol_o;
        end
    endtask
    // Cycles between two line clock rises
    task automatic line_period(output int c);
        int t;
        int seen;
        logic pl;
        c = 0;
        seen = 0;
        pl = lc_o;
        for (t = 0; t < 2000 && seen < 2; t++) begin
            @(posedge ref_clk);
            #1;
            if (seen == 1) c++;
            if (lc_o && !pl) seen++;
            pl = lc_o;
        end
    endtask
    // Polarity sampled early in two consecutive frames
    task automatic pol_pair(output logic p0, output logic p1);
        span(1'b0, n);
        repeat (5) @(posedge ref_clk);
        p0 = pol_o;
        @(posedge fm_o);
        repeat (5) @(posedge ref_clk);
        p1 = pol_o;
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Watchdog well beyond the expected run length
    initial begin
        #800000;
        num_errors++;
        conclude();
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'hd3a8));
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        for (i = 0; i < 4; i++) rd(addr_tab[i], 32'h0, "reset value");
        rd(8'h04, 32'h0, "unmapped");
        for (i = 0; i < 8; i++) begin
            d = $urandom;
            apb(addr_tab[i % 4], 1'b1, d & ((i % 4 == 0) ? 32'hffffffbf : 32'hffffffff));
            rd(addr_tab[i % 4], {24'h0, d[7:0] & mask_tab[i % 4]}, "masked rw");
        end
        $display("test registers done");
        apb(REG_POINTER_ADDR, 1'b1, 32'h80);
        apb(CONTROL_ADDR, 1'b1, 32'h05);
        apb(REG_POINTER_ADDR, 1'b1, 32'h00);
        repeat (3) @(posedge ref_clk);
        check("display off", {31'h0, screen_on_bit_en}, 32'h0);
        rd(CONTROL_ADDR, 32'h05, "kept control");
        $display("test display off done");
        apb(REG_POINTER_ADDR, 1'b1, 32'h80);
        apb(MODE_ADDR, 1'b1, 32'h00);
        for (i = 0; i < 8; i++) begin
            apb(CONTROL_ADDR, 1'b1, i);
            span(1'b0, n);
            check("lines per frame", n, lines_tab[i]);
        end
        $display("test duty done");
        apb(CONTROL_ADDR, 1'b1, 32'h00);
        for (i = 0; i < 7; i++) begin
            apb(MODE_ADDR, 1'b1, i);
            line_period(n);
            line_period(n);
            check("line period", n, TICKS * DRV * half_tab[i] / 2);
        end
        $display("test divider done");
        apb(MODE_ADDR, 1'b1, {27'h0, WAVE_FRAME, 3'h0});
        pol_pair(a, b);
        check("frame flip", {31'h0, a ^ b}, 32'h1);
        apb(MODE_ADDR, 1'b1, {27'h0, WAVE_N_LINE, 3'h0});
        apb(N_LINE_ADDR, 1'b1, 32'h04);
        span(1'b1, n);
        span(1'b1, n);
        check("n-line span", n, 4);
        pol_pair(a, b);
        check("n-line frame start", {31'h0, a ^ b}, 32'h0);
        apb(N_LINE_ADDR, 1'b1, 32'h24);
        pol_pair(a, b);
        check("combined flip", {31'h0, a ^ b}, 32'h1);
        $display("test waveforms done");
        slave_select <= 1'b1;
        repeat (6) @(posedge ref_clk);
        check("slave oe", {29'h0, lc_oe, fm_oe, pol_oe}, 32'h0);
        slave_select <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check("master oe", {29'h0, lc_oe, fm_oe, pol_oe}, 32'h7);
        $display("test master slave done");
        apb(REG_POINTER_ADDR, 1'b1, 32'h40);
        apb(CONTROL_ADDR, 1'b1, 32'h05);
        repeat (3) @(posedge ref_clk);
        check("standby pins", {27'h0, pslverr, osc, clk_o, lc_o, fm_o}, 32'h8);
        rd(REG_POINTER_ADDR, 32'h40, "sleep pointer");
        for (i = 1; i < 4; i++) rd(addr_tab[i], 32'h0, "cleared");
        apb(REG_POINTER_ADDR, 1'b1, 32'h87);
        rd(REG_POINTER_ADDR, 32'h0, "wake pointer");
        span(1'b0, n);
        check("wake lines", n, 32);
        line_period(n);
        check("wake period", n, TICKS * DRV / 2);
        $display("test standby done");
        conclude();
    end
endmodule
